/* src/atw_serial_readout.sv */
// serial readout port of a 12-bit sampling converter, apb slave
// Functional notes
// - strobe rise starts conversion when idle
// - further strobe rises ignored for 14 clocks
// - strobe duty cycle free, only rise counts
// - each shift clock rise advances one step
// - status bit out on second clock rise
// - then 12 result bits, msb first
// - bit stable at next clock rise
// - output floats until first conversion
// - two strobes without clock: nap, clock wakes
// - four strobes without clock: sleep, clock wakes
// - status bit low 12 ms after sleep
// - mode pin selects two's complement or binary
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module atw_serial_readout import atw_pkg::*;
#(
  parameter int REF_WAIT = REF_WAIT_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sampleStartStrobe,
  input wire logic shiftClock,
  input wire logic bipolarMode,
  input wire logic [DATA_BITS-1:0] analogCode,
  output logic resultOut,
  output logic resultOeN,
  output logic irq
);
  localparam int TW = $clog2(REF_WAIT + 1);

  typedef struct packed
  {
    atw_power_type power;
    logic [2:0] pdCount;
    logic started;
    logic refSettled;
    logic [TW-1:0] refTimer;
    logic useCode;
    logic [DATA_BITS-1:0] codeReg;
    logic [DATA_BITS-1:0] lastResult;
    logic [IRQ_BITS-1:0] irqStat;
    logic [IRQ_BITS-1:0] irqMask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dout;
    logic doutOeN;
    logic irq;
  } atw_top_type;

  atw_top_type st_q;
  atw_top_type st_d;

  logic sckRise;
  logic strobeRise;
  logic modeLevel;
  logic startReq;
  logic abortReq;
  logic [2:0] cnt;
  logic [IRQ_BITS-1:0] events;
  logic [IRQ_BITS-1:0] clrMask;
  logic [31:0] rd;
  logic addrOk;
  logic setup;
  logic access;

  atw_link_if link();

  atw_edge_sync u_sck_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .pin(shiftClock),
    .level(),
    .rise(sckRise)
  );

  atw_edge_sync u_strobe_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .pin(sampleStartStrobe),
    .level(),
    .rise(strobeRise)
  );

  atw_edge_sync u_mode_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .pin(bipolarMode),
    .level(modeLevel),
    .rise()
  );

  atw_sar_core u_core
  (
    .clk(clk),
    .rst_n(rst_n),
    .lk(link.core)
  );

  always_comb
  begin
    st_d = st_q;
    startReq = 1'b0;
    abortReq = 1'b0;
    events = '0;
    clrMask = '0;
    rd = '0;
    addrOk = 1'b1;
    setup = psel && !penable;
    access = psel && penable && st_q.pready;

    // strobe rises since the last clock rise
    cnt = sckRise ? 3'h0 : st_q.pdCount;
    if (strobeRise && cnt != SLEEP_EDGES)
      cnt = cnt + 3'h1;
    st_d.pdCount = cnt;

    unique case (st_q.power)
      PWR_ACTIVE:
      begin
        if (cnt == NAP_EDGES)
        begin
          st_d.power = PWR_NAP;
          abortReq = 1'b1;
          events[IRQ_NAP] = 1'b1;
        end
        else if (strobeRise && !link.busy)
          startReq = 1'b1;
      end
      PWR_NAP:
      begin
        if (sckRise)
        begin
          st_d.power = PWR_ACTIVE;
          events[IRQ_WAKE] = 1'b1;
        end
        else if (cnt == SLEEP_EDGES)
        begin
          st_d.power = PWR_SLEEP;
          events[IRQ_SLEEP] = 1'b1;
        end
      end
      PWR_SLEEP:
      begin
        if (sckRise)
        begin
          st_d.power = PWR_ACTIVE;
          events[IRQ_WAKE] = 1'b1;
        end
      end
      default:
        st_d.power = PWR_ACTIVE;
    endcase

    // reference settling after sleep
    if (st_q.power == PWR_SLEEP)
    begin
      st_d.refSettled = 1'b0;
      st_d.refTimer = '0;
    end
    else if (!st_q.refSettled)
    begin
      st_d.refTimer = st_q.refTimer + TW'(1);
      if (st_q.refTimer == TW'(REF_WAIT - 1))
        st_d.refSettled = 1'b1;
    end

    if (startReq)
      st_d.started = 1'b1;
    st_d.doutOeN = !st_d.started;
    st_d.dout = link.bitOut;
    if (link.done)
    begin
      st_d.lastResult = link.result;
      events[IRQ_DONE] = 1'b1;
    end

    // apb read decode at setup, data held through access
    unique case (paddr)
      OFS_CTRL: rd[CTRL_USE_CODE] = st_q.useCode;
      OFS_CODE: rd[DATA_BITS-1:0] = st_q.codeReg;
      OFS_STATUS:
      begin
        rd[STAT_BUSY] = link.busy;
        rd[STAT_NAP] = st_q.power == PWR_NAP;
        rd[STAT_SLEEP] = st_q.power == PWR_SLEEP;
        rd[STAT_REF] = st_q.refSettled;
        rd[STAT_LIVE] = st_q.started;
      end
      OFS_RESULT: rd[DATA_BITS-1:0] = st_q.lastResult;
      OFS_IRQ_STAT: rd[IRQ_BITS-1:0] = st_q.irqStat;
      OFS_IRQ_MASK: rd[IRQ_BITS-1:0] = st_q.irqMask;
      default: addrOk = 1'b0;
    endcase
    st_d.pready = setup;
    if (setup)
    begin
      st_d.prdata = pwrite ? 32'h00000000 : rd;
      st_d.pslverr = !addrOk;
    end

    if (access && pwrite)
    begin
      unique case (paddr)
        OFS_CTRL: st_d.useCode = pwdata[CTRL_USE_CODE];
        OFS_CODE: st_d.codeReg = pwdata[DATA_BITS-1:0];
        OFS_IRQ_STAT: clrMask = pwdata[IRQ_BITS-1:0];
        OFS_IRQ_MASK: st_d.irqMask = pwdata[IRQ_BITS-1:0];
        default: ;
      endcase
    end

    // set wins over write-one-to-clear
    st_d.irqStat = (st_q.irqStat & ~clrMask) | events;
    st_d.irq = |(st_d.irqStat & st_d.irqMask);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.power <= PWR_ACTIVE;
      st_q.refSettled <= REF_SETTLED_RESET;
      st_q.doutOeN <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign link.start = startReq;
  assign link.step = sckRise;
  assign link.abort = abortReq;
  assign link.bipolar = modeLevel;
  assign link.refBit = st_q.refSettled;
  assign link.sample = st_q.useCode ? st_q.codeReg : analogCode;

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign resultOut = st_q.dout;
  assign resultOeN = st_q.doutOeN;
  assign irq = st_q.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_start_accept: assert property (
    strobeRise && !sckRise && !link.busy && st_q.pdCount == 3'h0 &&
    st_q.power == PWR_ACTIVE |=> link.busy)
    else $error("idle strobe rise did not start conversion");
  a_hiz_until_start: assert property (
    !st_q.started |-> resultOeN)
    else $error("output driven before first conversion");
  a_dout_tracks: assert property (
    1'b1 |=> resultOut == $past(link.bitOut))
    else $error("serial output lost the stepped bit");
  a_nap_entry: assert property (
    st_q.power == PWR_ACTIVE && strobeRise && !sckRise &&
    st_q.pdCount == 3'h1 |=> st_q.power == PWR_NAP && !link.busy)
    else $error("second strobe did not enter nap");
  a_sleep_entry: assert property (
    st_q.power == PWR_NAP && strobeRise && !sckRise &&
    st_q.pdCount == 3'h3 |=> st_q.power == PWR_SLEEP)
    else $error("fourth strobe did not enter sleep");
  a_wake_on_clock: assert property (
    sckRise && st_q.power != PWR_ACTIVE |=> st_q.power == PWR_ACTIVE)
    else $error("clock rise did not wake");
  a_ref_low_sleep: assert property (
    st_q.power == PWR_SLEEP |=> !st_q.refSettled ##1 !st_q.refSettled)
    else $error("status bit high too soon after sleep");
  a_ref_wait: assert property (
    $rose(st_q.refSettled) |-> $past(st_q.refTimer) == TW'(REF_WAIT - 1))
    else $error("reference settle time wrong");
  a_irq_level: assert property (
    irq == |(st_q.irqStat & st_q.irqMask))
    else $error("interrupt level disagrees with status");

  c_frame_done: cover property (link.done);
  c_nap: cover property (st_q.power == PWR_NAP);
  c_sleep: cover property (st_q.power == PWR_SLEEP);
  c_wake_sleep: cover property (
    st_q.power == PWR_SLEEP ##1 st_q.power == PWR_ACTIVE);
endmodule : atw_serial_readout

/* src/atw_pkg.sv */
// constants and types for the three-wire converter readout
package atw_pkg;
  localparam int DATA_BITS = 12;
  localparam int IRQ_BITS = 4;
  localparam logic [3:0] STEP_REF = 4'h2;
  localparam logic [3:0] STEP_LAST = 4'hE;
  localparam logic [2:0] NAP_EDGES = 3'h2;
  localparam logic [2:0] SLEEP_EDGES = 3'h4;
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int REF_SLEW_US = 2000;
  localparam int REF_FLAG_US = 10000;
  localparam int REF_WAIT_CYCLES =
    (REF_SLEW_US + REF_FLAG_US) * (CLK_FREQ_HZ / 1000000);
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CODE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam int CTRL_USE_CODE = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NAP = 1;
  localparam int STAT_SLEEP = 2;
  localparam int STAT_REF = 3;
  localparam int STAT_LIVE = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NAP = 1;
  localparam int IRQ_SLEEP = 2;
  localparam int IRQ_WAKE = 3;
  localparam logic REF_SETTLED_RESET = 1'b1;
  typedef enum logic [1:0]
  {
    PWR_ACTIVE = 2'b00,
    PWR_NAP = 2'b01,
    PWR_SLEEP = 2'b10
  } atw_power_type;
endpackage : atw_pkg

/* src/atw_link_if.sv */
// signals between the readout control and the conversion core
`timescale 1ns/10ps
interface atw_link_if;
  import atw_pkg::*;
  logic start;
  logic step;
  logic abort;
  logic bipolar;
  logic refBit;
  logic [DATA_BITS-1:0] sample;
  logic busy;
  logic bitOut;
  logic done;
  logic [DATA_BITS-1:0] result;
  modport ctrl
  (
    output start, step, abort, bipolar, refBit, sample,
    input busy, bitOut, done, result
  );
  modport core
  (
    input start, step, abort, bipolar, refBit, sample,
    output busy, bitOut, done, result
  );
endinterface : atw_link_if

/* src/atw_edge_sync.sv */
// two-flop synchroniser with rising edge pulse
`timescale 1ns/10ps
module atw_edge_sync import atw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise
);
  typedef struct packed
  {
    logic meta;
    logic sync;
    logic last;
    logic rise;
  } atw_sync_type;

  atw_sync_type st_q;
  atw_sync_type st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.meta = pin;
    st_d.sync = st_q.meta;
    st_d.last = st_q.sync;
    st_d.rise = st_q.sync && !st_q.last;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign level = st_q.sync;
  assign rise = st_q.rise;
endmodule : atw_edge_sync

/* src/atw_sar_core.sv */
// successive approximation steps and serial bit sequencing
`timescale 1ns/10ps
module atw_sar_core import atw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  atw_link_if.core lk
);
  typedef struct packed
  {
    logic busy;
    logic [3:0] stepCnt;
    logic [DATA_BITS-1:0] code;
    logic bip;
    logic [DATA_BITS-1:0] result;
    logic bitOut;
    logic done;
  } atw_core_type;

  atw_core_type st_q;
  atw_core_type st_d;

  always_comb
  begin
    logic [3:0] idx;
    logic [DATA_BITS-1:0] trial;
    logic keep;
    idx = '0;
    trial = '0;
    keep = 1'b0;
    st_d = st_q;
    st_d.done = 1'b0;
    if (lk.abort)
      st_d.busy = 1'b0;
    else if (lk.start)
    begin
      // sample taken, first edge only acquires
      st_d.busy = 1'b1;
      st_d.stepCnt = '0;
      st_d.code = lk.sample;
      st_d.bip = lk.bipolar;
      st_d.result = '0;
      st_d.bitOut = 1'b0;
    end
    else if (lk.step && st_q.busy)
    begin
      st_d.stepCnt = st_q.stepCnt + 4'h1;
      if (st_d.stepCnt == STEP_REF)
        st_d.bitOut = lk.refBit;
      else if (st_d.stepCnt > STEP_REF)
      begin
        idx = STEP_LAST - st_d.stepCnt;
        trial = st_q.result | (12'h001 << idx);
        keep = trial <= st_q.code;
        if (keep)
          st_d.result = trial;
        // msb first, sign inverted for two's complement
        st_d.bitOut = keep ^
          (st_q.bip && st_d.stepCnt == STEP_REF + 4'h1);
      end
      if (st_d.stepCnt == STEP_LAST)
      begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign lk.busy = st_q.busy;
  assign lk.bitOut = st_q.bitOut;
  assign lk.done = st_q.done;
  assign lk.result = st_q.result;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_start_clears: assert property (
    lk.start && !lk.abort |=> st_q.busy && st_q.stepCnt == 4'h0)
    else $error("start did not open a conversion");
  a_no_restart: assert property (
    st_q.busy |-> !lk.start)
    else $error("strobe restarted a running conversion");
  a_frame_end: assert property (
    st_q.busy && lk.step && !lk.abort && !lk.start &&
    st_q.stepCnt == STEP_LAST - 4'h1 |=> !st_q.busy && st_q.done)
    else $error("conversion did not end after last step");
  a_ref_bit_out: assert property (
    st_q.busy && lk.step && !lk.abort && !lk.start &&
    st_q.stepCnt == STEP_REF - 4'h1 |=> st_q.bitOut == $past(lk.refBit))
    else $error("status bit not sent on second step");
  a_msb_coding: assert property (
    st_q.busy && lk.step && !lk.abort && !lk.start &&
    st_q.stepCnt == STEP_REF |=> st_q.bitOut == (st_q.code[11] ^ st_q.bip))
    else $error("first data bit not msb in selected coding");
  a_bit_hold: assert property (
    !lk.step && !lk.start |=> $stable(st_q.bitOut))
    else $error("output bit changed without a step");
endmodule : atw_sar_core

/* verification/atw_host_model.sv */
// host serial port model driving strobe and shift clock
`timescale 1ns/10ps
module atw_host_model
(
  input wire logic clk,
  input wire logic resultOut,
  input wire logic resultOeN,
  output logic sampleStartStrobe,
  output logic shiftClock
);
  logic lastBit;
  logic dataLine;
  initial
  begin
    sampleStartStrobe = 1'b0;
    shiftClock = 1'b0;
    lastBit = 1'b0;
  end
  // floating line seen as inverse of last driven bit
  always @(posedge clk)
    if (resultOeN === 1'b0)
      lastBit <= resultOut;
  assign dataLine = (resultOeN === 1'b0) ? resultOut : ~lastBit;
  // strobe one period wide, 16 clocks per frame; extra strobe at fall extraAt
  task automatic frame(input int extraAt, output logic [12:0] word);
    int k;
    word = '0;
    @(posedge clk);
    sampleStartStrobe <= 1'b1;
    repeat (4) @(posedge clk);
    for (k = 1; k <= 16; k++)
    begin
      if (k >= 3 && k <= 15)
        word = {word[11:0], dataLine};
      shiftClock <= 1'b1;
      repeat (4) @(posedge clk);
      shiftClock <= 1'b0;
      sampleStartStrobe <= (k == extraAt);
      repeat (4) @(posedge clk);
    end
  endtask : frame
  // strobe pulses with the shift clock standing still
  task automatic strobes(input int n);
    repeat (n)
    begin
      @(posedge clk);
      sampleStartStrobe <= 1'b1;
      repeat (8) @(posedge clk);
      sampleStartStrobe <= 1'b0;
      repeat (7) @(posedge clk);
    end
  endtask : strobes
  task automatic wake;
    @(posedge clk);
    shiftClock <= 1'b1;
    repeat (4) @(posedge clk);
    shiftClock <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : wake
endmodule : atw_host_model

/* verification/testbench.sv */
// self-checking bench for the serial readout block
`timescale 1ns/10ps
module testbench import atw_pkg::*; ;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic strobe, sclk, bipolarMode, resultOut, resultOeN, irq;
  logic [DATA_BITS-1:0] analogCode;
  int badCount, comparisons;
  atw_serial_readout #(.REF_WAIT(200)) uut
  (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sampleStartStrobe(strobe),
    .shiftClock(sclk), .bipolarMode(bipolarMode),
    .analogCode(analogCode), .resultOut(resultOut),
    .resultOeN(resultOeN), .irq(irq)
  );
  atw_host_model host
  (
    .clk(clk), .resultOut(resultOut), .resultOeN(resultOeN),
    .sampleStartStrobe(strobe), .shiftClock(sclk)
  );
  always #20 clk = ~clk;
  task automatic tally_and_finish;
    if (badCount == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      badCount++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16)
    begin
      badCount++;
      tally_and_finish();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp);
  endtask : rd
  task automatic fchk(input int x, input logic [12:0] exp);
    logic [12:0] w;
    host.frame(x, w);
    chk({19'h0, w}, {19'h0, exp});
  endtask : fchk
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    chk({31'h0, resultOeN}, 32'h1);
    rd(OFS_STATUS, 32'hFF, 32'h8);
    rd(OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rd(OFS_CODE, 32'hFFFFFFFF, 32'h0);
    rd(OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    rd(OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h80000000);
    host.wake();
    chk({31'h0, resultOeN}, 32'h1);
  endtask : t_reset
  task automatic t_frames;
    analogCode <= 12'hA5C;
    fchk(0, 13'h1A5C);
    chk({31'h0, resultOeN}, 32'h0);
    rd(OFS_RESULT, 32'hFFF, 32'hA5C);
    bipolarMode <= 1'b1;
    analogCode <= 12'h123;
    fchk(0, 13'h1923);
    analogCode <= 12'h000;
    fchk(0, 13'h1800);
    bipolarMode <= 1'b0;
  endtask : t_frames
  task automatic t_ignore;
    logic [12:0] w;
    analogCode <= 12'h3C3;
    fork
      host.frame(7, w);
      begin
        repeat (40) @(posedge clk);
        analogCode <= 12'hFFF;
      end
    join
    chk({19'h0, w}, 32'h13C3);
  endtask : t_ignore
  task automatic t_regs;
    wr(OFS_CODE, 32'h7FF);
    wr(OFS_CTRL, 32'h1);
    fchk(0, 13'h17FF);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_IRQ_STAT, 32'hF);
    wr(OFS_IRQ_MASK, 32'h1);
    fchk(0, 13'h1FFF);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STAT, 32'hF, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_STATUS, 32'hFF);
    rd(OFS_STATUS, 32'hFF, 32'h18);
  endtask : t_regs
  task automatic t_power;
    host.strobes(2);
    rd(OFS_STATUS, 32'h2, 32'h2);
    rd(OFS_IRQ_STAT, 32'hF, 32'h2);
    host.wake();
    rd(OFS_STATUS, 32'h6, 32'h0);
    analogCode <= 12'h456;
    fchk(0, 13'h1456);
    host.strobes(4);
    rd(OFS_STATUS, 32'h4, 32'h4);
    host.wake();
    rd(OFS_STATUS, 32'h4, 32'h0);
    rd(OFS_IRQ_STAT, 32'hF, 32'hF);
    fchk(0, 13'h0456);
    repeat (250) @(posedge clk);
    fchk(0, 13'h1456);
  endtask : t_power
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bipolarMode = 1'b0;
    analogCode = 12'h000;
    badCount = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_frames();
    t_ignore();
    t_regs();
    t_power();
    tally_and_finish();
  end
endmodule : testbench
